/* shared/cba_pkg.sv */
/*
  Shared constants and types for the CAN bus-access ends: bit timing in
  clock cycles, frame positions, fault counter limits, message layout.
  Assumes one common clock for both ends and a wired-AND bus.
*/
`default_nettype none
package cba_pkg;
  localparam int ID_W   = 11;
  localparam int DLC_W  = 4;
  localparam int DATA_W = 64;
  localparam int MSG_W  = ID_W + 1 + DLC_W + DATA_W;
  localparam int FRM_W  = MSG_W + 1;
  // Bus levels: dominant is logical zero
  localparam logic DOM = 1'b0;
  localparam logic REC = 1'b1;
  // Bit time of ten clocks; phase after an edge seen through the synchroniser
  localparam logic [3:0] BIT_LAST   = 4'h9;
  localparam logic [3:0] SAMPLE_PT  = 4'h6;
  localparam logic [3:0] EDGE_PHASE = 4'h3;
  localparam logic [3:0] IDLE_BITS  = 4'hB;
  // Bit positions inside a frame, start bit at zero
  localparam logic [6:0] POS_RTR     = 7'h0C;
  localparam logic [6:0] POS_DLC_END = 7'h10;
  localparam logic [3:0] DLC_MAX     = 4'h8;
  // Transmit error counter
  localparam logic [8:0] TEC_STEP    = 9'h008;
  localparam logic [8:0] TEC_PASSIVE = 9'h080;
  localparam logic [8:0] TEC_BUSOFF  = 9'h100;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic              rtr;
    logic [DLC_W-1:0]  dlc;
    logic [DATA_W-1:0] data;
  } cba_msg_t;

  typedef enum logic [1:0] {CBA_IDLE, CBA_FRAME, CBA_OFF} cba_state_t;
endpackage
`default_nettype wire

/* shared/cba_bus_if.sv */
/*
  Shared CAN bus between the controller end and a peer node.
  Each end drives dominant by raising its output enable; the wire is
  recessive unless some end drives it (wired-AND).
*/
`default_nettype none
interface cba_bus_if;
  logic dev_bus_out;
  logic dev_bus_oe;
  logic peer_bus_out;
  logic peer_bus_oe;
  logic bus_level;

  assign bus_level = ~((dev_bus_oe & ~dev_bus_out) | (peer_bus_oe & ~peer_bus_out));

  modport dev  (output dev_bus_out, dev_bus_oe, input bus_level);
  modport peer (output peer_bus_out, peer_bus_oe, input bus_level);
endinterface
`default_nettype wire

/* logic/cba_mac_dev.sv */
/*
  CAN bus-access controller: bus-free detection, start of frame,
  bit-wise arbitration with withdrawal, frame reception with identifier
  filtering, transmit buffer and transmit error counting.
  Assumes the bus input is asynchronous and all nodes share one bit rate.
*/
`default_nettype none
// Summary of operation
// - Resynchronize on recessive-to-dominant edges only
// - Sampling stays correct over thirteen edgeless bits
// - Start a message only while bus is free
// - Detect free bus versus incoming reception
// - Contention resolved bit by bit over identifier
// - Compare sent level with sampled level
// - Recessive sent, dominant read: withdraw at once
// - Data frame beats remote frame, same identifier
// - Lower identifier value means higher priority
// - Remote frame requests matching data frame
// - Accept messages by identifier filter only
// - All nodes accept at same bit
// - One fixed common bit rate
// - Exchange messages with link layer user
// - Error counter separates disturbance from failure
// - Dominant is zero, wins over recessive
// - Request bit dominant data, recessive remote
// - Single dominant start bit, all sync
module cba_mac_dev #(
  parameter int unsigned BUF_DEPTH = 2
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        clk_en_in,
  cba_bus_if.dev                           bus,
  input  wire logic                        tx_valid_in,
  output logic                             tx_ready_out,
  input  wire logic [cba_pkg::ID_W-1:0]    tx_id_in,
  input  wire logic                        tx_rtr_in,
  input  wire logic [cba_pkg::DLC_W-1:0]   tx_dlc_in,
  input  wire logic [cba_pkg::DATA_W-1:0]  tx_data_in,
  input  wire logic [cba_pkg::ID_W-1:0]    filt_id_in,
  input  wire logic [cba_pkg::ID_W-1:0]    filt_mask_in,
  output logic                             rx_valid_out,
  output logic [cba_pkg::ID_W-1:0]         rx_id_out,
  output logic                             rx_rtr_out,
  output logic [cba_pkg::DLC_W-1:0]        rx_dlc_out,
  output logic [cba_pkg::DATA_W-1:0]       rx_data_out,
  output logic                             tx_done_out,
  output logic                             arb_lost_out,
  output logic                             bus_idle_out,
  output logic                             err_passive_out,
  output logic                             bus_off_out
);
  import cba_pkg::*;

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  cba_state_t       st_q, st_d;
  logic [3:0]       cnt_q, cnt_d, idle_q, idle_d, dlc8;
  logic [6:0]       pos_q, pos_d, last_q, last_d, last_now;
  logic [8:0]       tec_q, tec_d;
  cba_msg_t         sh_q, sh_d, rxm_q, rxm_d, head;
  cba_msg_t         buf_q [BUF_DEPTH];
  cba_msg_t         buf_d [BUF_DEPTH];
  logic [FRM_W-1:0] frame;
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]      bcnt_q, bcnt_d;
  logic             sync1_q, sync2_q, prev_q;
  logic             tx_q, tx_d, oe_q, oe_d;
  logic             rdy_q, rdy_d, push, pop, b, fall, drv, fin;
  logic             rxv_q, rxv_d, done_q, done_d, lost_q, lost_d;
  logic             idl_q, idl_d, ep_q, ep_d, off_q, off_d;

  // Transmit buffer: head stays until sent, so a lost message is retried
  always_comb begin
    buf_d = buf_q;
    push  = tx_valid_in & rdy_q;
    if (push) begin
      buf_d[wr_q] = cba_msg_t'({tx_id_in, tx_rtr_in, tx_dlc_in, tx_data_in});
    end
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      wr_d = (wr_q == PW'(BUF_DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PW'(BUF_DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    bcnt_d = bcnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    rdy_d  = (bcnt_d != (PW + 1)'(BUF_DEPTH));
  end

  assign head  = buf_q[rd_q];
  assign frame = {DOM, head};

  // Bit timing, bus access, arbitration and reception
  always_comb begin
    st_d   = st_q;
    pos_d  = pos_q;
    last_d = last_q;
    sh_d   = sh_q;
    idle_d = idle_q;
    tx_d   = tx_q;
    oe_d   = oe_q;
    tec_d  = tec_q;
    rxm_d  = rxm_q;
    rxv_d  = 1'b0;
    done_d = 1'b0;
    lost_d = 1'b0;
    pop    = 1'b0;
    fin    = 1'b0;
    b      = sync2_q;
    drv    = oe_q ? DOM : REC;
    fall   = prev_q & ~sync2_q;
    dlc8   = 4'h0;
    last_now = last_q;
    cnt_d  = (cnt_q == BIT_LAST) ? 4'h0 : cnt_q + 4'h1;
    if (fall && st_q != CBA_OFF) begin
      cnt_d = EDGE_PHASE;
    end
    if (cnt_q == SAMPLE_PT && st_q != CBA_OFF) begin
      idle_d = (b == DOM) ? 4'h0 : ((idle_q == IDLE_BITS) ? idle_q : idle_q + 4'h1);
      if (st_q == CBA_IDLE) begin
        if (b == DOM) begin
          st_d  = CBA_FRAME;
          pos_d = 7'h01;
          sh_d  = '0;
        end
      end else begin
        sh_d[MSG_W - int'(pos_q)] = b;
        if (pos_q == POS_DLC_END) begin
          dlc8     = (sh_d.dlc > DLC_MAX) ? DLC_MAX : sh_d.dlc;
          last_now = sh_d.rtr ? POS_DLC_END : POS_DLC_END + {dlc8, 3'b000};
          last_d   = last_now;
        end
        fin = (pos_q >= POS_DLC_END) && (pos_q == last_now);
        if (tx_q && drv != b) begin
          tx_d = 1'b0;
          oe_d = 1'b0;
          if (pos_q <= POS_RTR && drv == REC) begin
            lost_d = 1'b1;
            // Loser stays aligned with the frame as a receiver
            pos_d  = pos_q + 7'h01;
          end else begin
            tec_d  = tec_q + TEC_STEP;
            st_d   = CBA_IDLE;
            idle_d = 4'h0;
            pos_d  = 7'h00;
            fin    = 1'b0;
          end
        end else if (fin) begin
          st_d   = CBA_IDLE;
          idle_d = 4'h0;
          pos_d  = 7'h00;
          if (tx_q) begin
            tx_d   = 1'b0;
            done_d = 1'b1;
            pop    = 1'b1;
            tec_d  = (tec_q == 9'h000) ? tec_q : tec_q - 9'h001;
          end else if (((sh_d.id ^ filt_id_in) & filt_mask_in) == '0) begin
            rxv_d = 1'b1;
            rxm_d = sh_d;
          end
        end else begin
          pos_d = pos_q + 7'h01;
        end
      end
      if (tec_d >= TEC_BUSOFF) begin
        st_d = CBA_OFF;
        tx_d = 1'b0;
        oe_d = 1'b0;
      end
    end
    if (cnt_q == BIT_LAST && st_q != CBA_OFF) begin
      if (st_q == CBA_IDLE) begin
        if (bcnt_q != '0 && idle_q == IDLE_BITS && b == REC && !fall) begin
          tx_d = 1'b1;
          oe_d = 1'b1;
        end else begin
          oe_d = 1'b0;
        end
      end else begin
        oe_d = tx_q && (frame[FRM_W - 1 - int'(pos_q)] == DOM);
      end
    end
    idl_d = (idle_d == IDLE_BITS);
    ep_d  = (tec_d >= TEC_PASSIVE);
    off_d = (st_d == CBA_OFF);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_q   <= '{default: '0};
      wr_q    <= '0;
      rd_q    <= '0;
      bcnt_q  <= '0;
      rdy_q   <= 1'b0;
      sync1_q <= REC;
      sync2_q <= REC;
      prev_q  <= REC;
      st_q    <= CBA_IDLE;
      cnt_q   <= 4'h0;
      pos_q   <= 7'h00;
      last_q  <= 7'h00;
      sh_q    <= '0;
      idle_q  <= 4'h0;
      tx_q    <= 1'b0;
      oe_q    <= 1'b0;
      tec_q   <= 9'h000;
      rxm_q   <= '0;
      rxv_q   <= 1'b0;
      done_q  <= 1'b0;
      lost_q  <= 1'b0;
      idl_q   <= 1'b0;
      ep_q    <= 1'b0;
      off_q   <= 1'b0;
    end else if (clk_en_in) begin
      buf_q   <= buf_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      bcnt_q  <= bcnt_d;
      rdy_q   <= rdy_d;
      sync1_q <= bus.bus_level;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      pos_q   <= pos_d;
      last_q  <= last_d;
      sh_q    <= sh_d;
      idle_q  <= idle_d;
      tx_q    <= tx_d;
      oe_q    <= oe_d;
      tec_q   <= tec_d;
      rxm_q   <= rxm_d;
      rxv_q   <= rxv_d;
      done_q  <= done_d;
      lost_q  <= lost_d;
      idl_q   <= idl_d;
      ep_q    <= ep_d;
      off_q   <= off_d;
    end
  end

  assign bus.dev_bus_out = DOM;
  assign bus.dev_bus_oe  = oe_q;
  assign tx_ready_out    = rdy_q;
  assign rx_valid_out    = rxv_q;
  assign rx_id_out       = rxm_q.id;
  assign rx_rtr_out      = rxm_q.rtr;
  assign rx_dlc_out      = rxm_q.dlc;
  assign rx_data_out     = rxm_q.data;
  assign tx_done_out     = done_q;
  assign arb_lost_out    = lost_q;
  assign bus_idle_out    = idl_q;
  assign err_passive_out = ep_q;
  assign bus_off_out     = off_q;
endmodule
`default_nettype wire

/* logic/cba_peer_node.sv */
/*
  Peer CAN node on the shared bus: holds one message, contends for the
  bus by bit-wise arbitration and receives every frame it did not send.
  Assumes the same bit timing and clock as the controller end.
*/
`default_nettype none
module cba_peer_node (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        clk_en_in,
  cba_bus_if.peer                          bus,
  input  wire logic                        req_valid_in,
  output logic                             req_ready_out,
  input  wire logic [cba_pkg::MSG_W-1:0]   req_msg_in,
  output logic                             rx_valid_out,
  output logic [cba_pkg::MSG_W-1:0]        rx_msg_out,
  output logic                             tx_done_out,
  output logic                             arb_lost_out
);
  import cba_pkg::*;

  cba_state_t       st_q, st_d;
  logic [3:0]       cnt_q, cnt_d, idle_q, idle_d, dlc8;
  logic [6:0]       pos_q, pos_d, last_q, last_d, last_now;
  cba_msg_t         sh_q, sh_d, rxm_q, rxm_d, msg_q, msg_d;
  logic [FRM_W-1:0] frame;
  logic             sync1_q, sync2_q, prev_q, b, fall, drv, fin;
  logic             pend_q, pend_d, tx_q, tx_d, oe_q, oe_d;
  logic             rxv_q, rxv_d, done_q, done_d, lost_q, lost_d;

  assign frame = {DOM, msg_q};

  always_comb begin
    st_d   = st_q;
    pos_d  = pos_q;
    last_d = last_q;
    sh_d   = sh_q;
    idle_d = idle_q;
    tx_d   = tx_q;
    oe_d   = oe_q;
    rxm_d  = rxm_q;
    msg_d  = msg_q;
    pend_d = pend_q;
    rxv_d  = 1'b0;
    done_d = 1'b0;
    lost_d = 1'b0;
    fin    = 1'b0;
    b      = sync2_q;
    drv    = oe_q ? DOM : REC;
    fall   = prev_q & ~sync2_q;
    dlc8   = 4'h0;
    last_now = last_q;
    if (req_valid_in && !pend_q) begin
      pend_d = 1'b1;
      msg_d  = cba_msg_t'(req_msg_in);
    end
    cnt_d = fall ? EDGE_PHASE : ((cnt_q == BIT_LAST) ? 4'h0 : cnt_q + 4'h1);
    if (cnt_q == SAMPLE_PT) begin
      idle_d = (b == DOM) ? 4'h0 : ((idle_q == IDLE_BITS) ? idle_q : idle_q + 4'h1);
      if (st_q == CBA_FRAME) begin
        sh_d[MSG_W - int'(pos_q)] = b;
        if (pos_q == POS_DLC_END) begin
          dlc8     = (sh_d.dlc > DLC_MAX) ? DLC_MAX : sh_d.dlc;
          last_now = sh_d.rtr ? POS_DLC_END : POS_DLC_END + {dlc8, 3'b000};
          last_d   = last_now;
        end
        fin = (pos_q >= POS_DLC_END) && (pos_q == last_now);
        if (tx_q && drv != b) begin
          tx_d = 1'b0;
          oe_d = 1'b0;
          if (pos_q <= POS_RTR && drv == REC) begin
            lost_d = 1'b1;
            pos_d  = pos_q + 7'h01;
          end else begin
            st_d   = CBA_IDLE;
            idle_d = 4'h0;
            pos_d  = 7'h00;
            fin    = 1'b0;
          end
        end else if (fin) begin
          st_d   = CBA_IDLE;
          idle_d = 4'h0;
          pos_d  = 7'h00;
          if (tx_q) begin
            tx_d   = 1'b0;
            done_d = 1'b1;
            pend_d = 1'b0;
          end else begin
            rxv_d = 1'b1;
            rxm_d = sh_d;
          end
        end else begin
          pos_d = pos_q + 7'h01;
        end
      end else if (b == DOM) begin
        st_d  = CBA_FRAME;
        pos_d = 7'h01;
        sh_d  = '0;
      end
    end
    if (cnt_q == BIT_LAST) begin
      if (st_q == CBA_FRAME) begin
        oe_d = tx_q && (frame[FRM_W - 1 - int'(pos_q)] == DOM);
      end else if (pend_q && idle_q == IDLE_BITS && b == REC && !fall) begin
        tx_d = 1'b1;
        oe_d = 1'b1;
      end else begin
        oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= REC;
      sync2_q <= REC;
      prev_q  <= REC;
      st_q    <= CBA_IDLE;
      cnt_q   <= 4'h0;
      pos_q   <= 7'h00;
      last_q  <= 7'h00;
      sh_q    <= '0;
      idle_q  <= 4'h0;
      tx_q    <= 1'b0;
      oe_q    <= 1'b0;
      rxm_q   <= '0;
      msg_q   <= '0;
      pend_q  <= 1'b0;
      rxv_q   <= 1'b0;
      done_q  <= 1'b0;
      lost_q  <= 1'b0;
    end else if (clk_en_in) begin
      sync1_q <= bus.bus_level;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      pos_q   <= pos_d;
      last_q  <= last_d;
      sh_q    <= sh_d;
      idle_q  <= idle_d;
      tx_q    <= tx_d;
      oe_q    <= oe_d;
      rxm_q   <= rxm_d;
      msg_q   <= msg_d;
      pend_q  <= pend_d;
      rxv_q   <= rxv_d;
      done_q  <= done_d;
      lost_q  <= lost_d;
    end
  end

  assign bus.peer_bus_out = DOM;
  assign bus.peer_bus_oe  = oe_q;
  assign req_ready_out    = ~pend_q;
  assign rx_valid_out     = rxv_q;
  assign rx_msg_out       = rxm_q;
  assign tx_done_out      = done_q;
  assign arb_lost_out     = lost_q;
endmodule
`default_nettype wire

/* tb/cba_bus_monitor.sv */
/*
  Checker for the shared bus wires between the two ends.
  Assumes one clock and an asynchronous active-low reset.
*/
`default_nettype none
module cba_bus_monitor (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic dev_bus_out,
  input  wire logic dev_bus_oe,
  input  wire logic peer_bus_out,
  input  wire logic peer_bus_oe,
  input  wire logic bus_level
);
  import cba_pkg::*;
  logic [7:0] rec_q;
  logic [7:0] age_q;
  logic [7:0] rst_q;
  logic [3:0] ph_q;
  logic       oe_p_q;
  logic       both_q;
  logic       lost_q;

  // Run of recessive cycles, cycles since reset, bit grid of the device
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rec_q  <= 8'h00;
      age_q  <= 8'h00;
      rst_q  <= 8'h00;
      ph_q   <= 4'h0;
      oe_p_q <= 1'b0;
      both_q <= 1'b0;
      lost_q <= 1'b0;
    end else begin
      rec_q  <= bus_level ? ((rec_q == 8'hFF) ? rec_q : rec_q + 8'h01) : 8'h00;
      rst_q  <= (rst_q == 8'hFF) ? rst_q : rst_q + 8'h01;
      age_q  <= (age_q == 8'hFF) ? age_q : age_q + 8'h01;
      oe_p_q <= dev_bus_oe;
      ph_q   <= (dev_bus_oe && !oe_p_q) ? 4'h1 : ((ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1);
      if (dev_bus_oe && peer_bus_oe && rec_q >= 8'h64) begin
        both_q <= 1'b1;
        age_q  <= 8'h00;
      end else if (rec_q >= 8'h64) begin
        both_q <= 1'b0;
        lost_q <= 1'b0;
      end else if (both_q && peer_bus_oe && !dev_bus_oe) begin
        lost_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_dev_drives_dom: assert property (dev_bus_oe |-> dev_bus_out == DOM)
    else $error("device drives a recessive value");
  a_peer_drives_dom: assert property (peer_bus_oe |-> peer_bus_out == DOM)
    else $error("peer drives a recessive value");
  a_dev_bit_len: assert property ($rose(dev_bus_oe) |-> dev_bus_oe [*8])
    else $error("device dominant bit too short");
  a_peer_bit_len: assert property ($rose(peer_bus_oe) |-> peer_bus_oe [*8])
    else $error("peer dominant bit too short");
  a_quiet_after_reset: assert property (rst_q < 8'h6E |-> !dev_bus_oe && !peer_bus_oe)
    else $error("start before eleven idle bits");
  a_loser_stays_off: assert property (lost_q |-> !dev_bus_oe)
    else $error("device drives after losing");
  a_single_winner: assert property (both_q && age_q > 8'h82 |-> !(dev_bus_oe && peer_bus_oe))
    else $error("two transmitters after arbitration");
  a_fall_on_grid: assert property ($fell(dev_bus_oe) |-> ph_q == 4'h0)
    else $error("device bit edge off its grid");

  c_contend: cover property (both_q && lost_q);
  c_dev_alone: cover property ($rose(dev_bus_oe) && !peer_bus_oe);
  c_peer_alone: cover property ($rose(peer_bus_oe) && !dev_bus_oe);
endmodule
`default_nettype wire

/* tb/test_can_bus_access_arbitration.sv */
/*
  Bench for the two bus-access ends joined by one bus interface.
  Assumes package, interface and both design ends are compiled first.
*/
`default_nettype none
module test_can_bus_access_arbitration;
  timeunit 1ns;
  timeprecision 100ps;
  import cba_pkg::*;
  logic                 clk_in = 1'b0;
  logic                 rst_n_in = 1'b0;
  logic                 dv = 1'b0;
  logic                 pv = 1'b0;
  cba_msg_t             dm = '0;
  cba_msg_t             pm = '0;
  logic [ID_W-1:0]      fid = '0;
  logic [ID_W-1:0]      fmask = '0;
  logic                 d_rdy, d_rxv, d_rtr, d_done, d_lost, d_idle, d_ep, d_bo;
  logic [ID_W-1:0]      d_id;
  logic [DLC_W-1:0]     d_dlc;
  logic [DATA_W-1:0]    d_data;
  logic                 p_rdy, p_rxv, p_done, p_lost;
  logic [MSG_W-1:0]     p_rx;
  int                   bad_count = 0;
  int                   cmp_count = 0;
  int                   n_drx, n_dlost, n_ddone, n_pdone, n_plost, n_prx;

  cba_bus_if bus ();
  cba_mac_dev u_cba_mac_dev (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .bus(bus.dev), .tx_valid_in(dv), .tx_ready_out(d_rdy), .tx_id_in(dm.id),
    .tx_rtr_in(dm.rtr), .tx_dlc_in(dm.dlc), .tx_data_in(dm.data), .filt_id_in(fid),
    .filt_mask_in(fmask), .rx_valid_out(d_rxv), .rx_id_out(d_id), .rx_rtr_out(d_rtr),
    .rx_dlc_out(d_dlc), .rx_data_out(d_data), .tx_done_out(d_done),
    .arb_lost_out(d_lost), .bus_idle_out(d_idle), .err_passive_out(d_ep),
    .bus_off_out(d_bo));
  cba_peer_node u_cba_peer_node (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .bus(bus.peer), .req_valid_in(pv), .req_ready_out(p_rdy), .req_msg_in(pm),
    .rx_valid_out(p_rxv), .rx_msg_out(p_rx), .tx_done_out(p_done), .arb_lost_out(p_lost));
  cba_bus_monitor u_cba_bus_monitor (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .dev_bus_out(bus.dev_bus_out), .dev_bus_oe(bus.dev_bus_oe),
    .peer_bus_out(bus.peer_bus_out), .peer_bus_oe(bus.peer_bus_oe),
    .bus_level(bus.bus_level));

  always #2.5 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    if (d_rxv === 1'b1) n_drx++;
    if (d_lost === 1'b1) n_dlost++;
    if (d_done === 1'b1) n_ddone++;
    if (p_done === 1'b1) n_pdone++;
    if (p_lost === 1'b1) n_plost++;
    if (p_rxv === 1'b1) n_prx++;
  end

  task automatic chk(input string name, input logic [MSG_W-1:0] exp, input logic [MSG_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic do_reset();
    {n_drx, n_dlost, n_ddone, n_pdone, n_plost, n_prx} = '0;
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
  endtask

  task automatic push(input logic to_peer, input cba_msg_t m);
    int i;
    if (to_peer) pm <= m; else dm <= m;
    if (to_peer) pv <= 1'b1; else dv <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_in);
      if ((to_peer ? p_rdy : d_rdy) === 1'b1) break;
    end
    if (to_peer) pv <= 1'b0; else dv <= 1'b0;
    if (i == 50) chk("offer taken", 1'b1, 1'b0);
  endtask

  task automatic wait_done(input int n);
    int i;
    for (i = 0; i < 3000 && n_ddone + n_pdone < n; i++) @(posedge clk_in);
    if (i == 3000) chk("frame completion", 1'b1, 1'b0);
    repeat (5) @(posedge clk_in);
  endtask

  // Reads start bit, identifier and request bit off the wire, mid-bit
  task automatic wire_chk(input cba_msg_t m);
    logic [12:0] seen;
    for (int i = 0; i < 300 && bus.bus_level !== DOM; i++) @(posedge clk_in);
    repeat (4) @(posedge clk_in);
    for (int k = 12; k >= 0; k--) begin
      seen[k] = bus.bus_level;
      repeat (10) @(posedge clk_in);
    end
    chk("wire head", {DOM, m.id, m.rtr}, seen);
  endtask

  // Both ends start on the same bit; the loser receives, then retries
  task automatic contend(input cba_msg_t md, input cba_msg_t mp, input logic dev_wins);
    do_reset();
    push(1'b0, md);
    push(1'b1, mp);
    wait_done(2);
    chk("device lost", !dev_wins, n_dlost);
    chk("peer lost", dev_wins, n_plost);
    chk("device retried", 1, n_ddone);
    chk("peer retried", 1, n_pdone);
    chk("device rx", mp, {d_id, d_rtr, d_dlc, d_data});
    chk("peer rx head", {md.id, md.rtr}, p_rx[MSG_W-1 -: ID_W+1]);
    chk("peer rx", md, p_rx);
  endtask

  task automatic report_and_stop();
    $display("counts: %0d compared, %0d bad", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    $display("BAD watchdog expected end seen hang");
    report_and_stop();
  end

  initial begin
    do_reset();
    chk("peer ready", 1'b1, p_rdy);
    push(1'b0, '{11'h123, 1'b0, 4'h8, 64'h0123_4567_89AB_CDEF});
    wire_chk('{11'h123, 1'b0, 4'h8, 64'h0});
    wait_done(1);
    chk("peer rx", {11'h123, 1'b0, 4'h8, 64'h0123_4567_89AB_CDEF}, p_rx);
    chk("peer rx count", 1, n_prx);
    chk("own frame not delivered", 0, n_drx);
    repeat (120) @(posedge clk_in);
    chk("bus idle", 1'b1, d_idle);
    $display("test single transmit done");
    fid <= 11'h456;
    fmask <= 11'h7FF;
    push(1'b1, '{11'h456, 1'b0, 4'h2, 64'hA5C3_0000_0000_0000});
    wait_done(2);
    chk("filtered rx", {11'h456, 1'b0, 4'h2, 64'hA5C3_0000_0000_0000},
        {d_id, d_rtr, d_dlc, d_data});
    push(1'b1, '{11'h457, 1'b0, 4'h1, 64'h5A00_0000_0000_0000});
    wait_done(3);
    chk("filter refuses", 1, n_drx);
    $display("test filter done");
    // Two offers in a row fill the transmit buffer; both must go out in order
    push(1'b0, '{11'h0A1, 1'b0, 4'h1, 64'h1100_0000_0000_0000});
    @(posedge clk_in);
    push(1'b0, '{11'h0A2, 1'b0, 4'h1, 64'h2200_0000_0000_0000});
    @(posedge clk_in);
    chk("buffer full", 1'b0, d_rdy);
    wait_done(5);
    chk("second buffered frame", {11'h0A2, 1'b0, 4'h1, 64'h2200_0000_0000_0000},
        p_rx);
    chk("buffered frames sent", 3, n_ddone);
    chk("peer rx count after buffer", 3, n_prx);
    $display("test buffer done");
    fmask <= 11'h000;
    contend('{11'h200, 1'b0, 4'h8, 64'h1122_3344_5566_7788},
            '{11'h100, 1'b0, 4'h8, 64'h8877_6655_4433_2211}, 1'b0);
    contend('{11'h300, 1'b1, 4'h4, 64'h0},
            '{11'h300, 1'b0, 4'h8, 64'hCAFE_F00D_1234_5678}, 1'b0);
    contend('{11'h0F0, 1'b0, 4'h1, 64'h3300_0000_0000_0000},
            '{11'h0F8, 1'b0, 4'h1, 64'h4400_0000_0000_0000}, 1'b1);
    chk("error counter quiet", 2'b00, {d_ep, d_bo});
    $display("test arbitration done");
    report_and_stop();
  end
endmodule
`default_nettype wire
